// File: hdl/hms_serial_access.sv
// Purpose: Serial register access and limit alarms of a hardware monitor.
// Assumes: scl and sda are synchronous to mclk and far slower than it.
// Notes: The converter sits outside; this block steers and stores it.
`include "hms_consts.svh"
module hms_serial_access import hms_pkg::*; #(
   parameter int NCH = `HMS_NCH,
   parameter int NADC = `HMS_NADC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Converter handshake
   output logic adc_start,
   output logic [3:0] adc_chan,
   output logic adc_int5v_sel,
   input wire logic adc_done,
   input wire logic [7:0] adc_data,
   // Fan counts and pin function
   input wire logic [(NCH-NADC)*8-1:0] fan_cnt,
   output logic [1:0] neg_low_voltage_input_mode,
   // Alarm
   output logic beep
);
   localparam int NST = NCH + 1;
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Status lives in two 8-bit registers and channel codes are 4 bits
   // At least one fan channel is needed, or the fan port has no width
   if (NCH > 15 || NADC >= NCH || NADC <= `HMS_CH_TEMP1) begin : g_chk
      $error("hms_serial_access: unsupported channel counts");
   end
   // Full scale is 256 codes of one step each
   localparam int FSR_UV = 256 * `HMS_LSB_UV;
   if (FSR_UV != `HMS_FSR_MV * 1000) begin : g_lsb
      $error("hms_serial_access: converter step does not match full scale");
   end
   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [7:0] val_r [NCH];
   logic [7:0] lim_r [NCH];
   logic [7:0] cfg_r, ssel_r, idx_r, ptr_r, scfg_r;
   logic [6:0] paddr_r;
   logic [1:0] pmode_r;
   logic [15:0] tos_r, thyst_r;
   logic [15:0] isr_r;
   logic [NCH-1:0] over_r;
   logic beep_r;
   // ****************************************************************
   // Serial engine
   // ****************************************************************
   hms_ser_t st_r;
   logic scl_q, sda_q, rw_r, sens_r, first_r, lo_r, nack_r, sda_oe_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, tx_r;
   wire scl_rise = scl_i & ~scl_q;
   wire scl_fall = ~scl_i & scl_q;
   wire start_c = scl_i & scl_q & sda_q & ~sda_i;
   wire stop_c = scl_i & scl_q & ~sda_q & sda_i;
   wire byte_end = scl_fall & (cnt_r == `HMS_NBITS);
   wire [6:0] saddr = {`HMS_SENS_HI, ssel_r[2:0]};
   wire hit_p = (sh_r[7:1] == paddr_r);
   wire hit_s = (sh_r[7:1] == saddr);
   wire addr_ok = (st_r == S_ADDR) & byte_end & (hit_p | hit_s);
   wire wr_byte = (st_r == S_WR) & byte_end;
   wire wr_reg = wr_byte & ~first_r & ~sens_r;
   wire wr_sens = wr_byte & ~first_r & sens_r;
   wire rd_load = scl_fall & (((st_r == S_ACK) & rw_r) | ((st_r == S_RACK) & ~nack_r));
   wire [7:0] vidx = idx_r - `HMS_VAL_BASE;
   wire [7:0] lidx = idx_r - `HMS_LIM_BASE;
   wire in_val = (idx_r >= `HMS_VAL_BASE) && (vidx < 8'(NCH));
   wire in_lim = (idx_r >= `HMS_LIM_BASE) && (lidx < 8'(NCH));
   logic [7:0] prd, srd;
   // Primary read decode
   always_comb begin
      prd = 8'h00;
      if (in_val) prd = val_r[vidx[3:0]];
      else if (in_lim) prd = lim_r[lidx[3:0]];
      else begin
         case (idx_r)
            `HMS_CFG_ADDR: prd = cfg_r;
            `HMS_ISR1_ADDR: prd = isr_r[7:0];
            `HMS_ISR2_ADDR: prd = isr_r[15:8];
            `HMS_PADDR_ADDR: prd = {1'b0, paddr_r};
            `HMS_SSEL_ADDR: prd = ssel_r;
            `HMS_PMODE_ADDR: prd = {6'h00, pmode_r};
            default: prd = 8'h00;
         endcase
      end
   end
   // Sensor read decode; two-byte registers give high byte first
   always_comb begin
      case (ptr_r[1:0])
         2'b00: srd = lo_r ? 8'h00 : val_r[`HMS_CH_TEMP1];
         2'b01: srd = scfg_r;
         2'b10: srd = lo_r ? thyst_r[7:0] : thyst_r[15:8];
         default: srd = lo_r ? tos_r[7:0] : tos_r[15:8];
      endcase
   end
   wire [7:0] rd_byte = sens_r ? srd : prd;
   // Status clear by read; only the primary address reaches it
   wire clr1 = rd_load & ~sens_r & (idx_r == `HMS_ISR1_ADDR);
   wire clr2 = rd_load & ~sens_r & (idx_r == `HMS_ISR2_ADDR);
   // Bus state; start and stop win over any bit activity
   always_ff @(posedge mclk) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (srst) begin
         st_r <= S_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         sda_oe_r <= 1'b0;
         rw_r <= 1'b0;
         sens_r <= 1'b0;
         first_r <= 1'b0;
         nack_r <= 1'b0;
         lo_r <= 1'b0;
      end else if (start_c) begin
         st_r <= S_ADDR;
         cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else if (stop_c) begin
         st_r <= S_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         if (scl_rise && (st_r == S_ADDR || st_r == S_WR)) begin
            sh_r <= {sh_r[6:0], sda_i};
            cnt_r <= cnt_r + 4'h1;
         end
         if (scl_rise && st_r == S_RD) cnt_r <= cnt_r + 4'h1;
         if (scl_rise && st_r == S_RACK) nack_r <= sda_i;
         case (st_r)
            S_ADDR: if (byte_end) begin
               st_r <= addr_ok ? S_ACK : S_IDLE;
               sda_oe_r <= addr_ok;
               rw_r <= sh_r[0];
               sens_r <= hit_s & ~hit_p;
               first_r <= ~sh_r[0];
               lo_r <= 1'b0;
            end
            S_WR: if (byte_end) begin
               st_r <= S_ACK;
               sda_oe_r <= 1'b1;
               first_r <= 1'b0;
               if (!first_r && sens_r) lo_r <= ~lo_r;
               if (first_r) lo_r <= 1'b0;
            end
            S_ACK: if (scl_fall) begin
               cnt_r <= 4'h0;
               st_r <= rw_r ? S_RD : S_WR;
               tx_r <= rd_byte;
               sda_oe_r <= rw_r & ~rd_byte[7];
            end
            S_RD: if (scl_fall) begin
               if (cnt_r == `HMS_NBITS) begin
                  st_r <= S_RACK;
                  sda_oe_r <= 1'b0;
                  lo_r <= ~lo_r;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  sda_oe_r <= ~tx_r[6];
               end
            end
            S_RACK: if (scl_fall) begin
               cnt_r <= 4'h0;
               st_r <= nack_r ? S_IDLE : S_RD;
               tx_r <= rd_byte;
               sda_oe_r <= ~nack_r & ~rd_byte[7];
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
   // ****************************************************************
   // Sampling sequencer
   // ****************************************************************
   hms_mon_t mon_r;
   logic [3:0] ch_r;
   logic adc_start_r;
   wire run = cfg_r[`HMS_CFG_START];
   wire [3:0] fidx = ch_r - 4'(NADC);
   wire store = (mon_r == M_WAIT & adc_done) | (mon_r == M_CONV & ch_r >= 4'(NADC));
   wire [7:0] sample = (mon_r == M_WAIT) ? adc_data : fan_cnt[fidx*8 +: 8];
   wire is_over = val_r[ch_r] > lim_r[ch_r];
   wire t1_over = (ch_r == 4'(`HMS_CH_TEMP1)) & (val_r[ch_r] > tos_r[15:8]);
   logic [NST-1:0] set_v;
   // One status set term per channel, plus one for the sensor over-temperature limit
   for (genvar g = 0; g < NST; g++) begin : g_set
      if (g < NCH) begin : g_ch
         assign set_v[g] = (mon_r == M_CMP) & (ch_r == 4'(g)) & is_over;
      end else begin : g_t1
         assign set_v[g] = (mon_r == M_CMP) & t1_over;
      end
   end
   wire [15:0] set_w = 16'(set_v);
   wire [15:0] clr_w = {{8{clr2}}, {8{clr1}}};
   // Walk channels one at a time; fans are latched without the converter
   always_ff @(posedge mclk) begin
      if (srst) begin
         mon_r <= M_IDLE;
         ch_r <= 4'h0;
         adc_start_r <= 1'b0;
         over_r <= '0;
         isr_r <= 16'h0000;
         beep_r <= 1'b0;
      end else begin
         adc_start_r <= 1'b0;
         isr_r <= (isr_r & ~clr_w) | set_w;
         beep_r <= |over_r;
         case (mon_r)
            M_IDLE: if (run) mon_r <= M_CONV;
            M_CONV: begin
               adc_start_r <= (ch_r < 4'(NADC));
               mon_r <= (ch_r < 4'(NADC)) ? M_WAIT : M_CMP;
            end
            M_WAIT: if (adc_done) mon_r <= M_CMP;
            M_CMP: begin
               over_r[ch_r] <= is_over;
               ch_r <= (ch_r == 4'(NCH - 1)) ? 4'h0 : ch_r + 4'h1;
               mon_r <= run ? M_CONV : M_IDLE;
            end
            default: mon_r <= M_IDLE;
         endcase
      end
   end
   // ****************************************************************
   // Register writes
   // ****************************************************************
   wire [7:0] wv = sh_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int i = 0; i < NCH; i++) begin
            val_r[i] <= 8'h00;
            lim_r[i] <= `HMS_LIM_RST;
         end
         cfg_r <= 8'h00;
         idx_r <= 8'h00;
         ptr_r <= 8'h00;
         scfg_r <= 8'h00;
         paddr_r <= `HMS_PADDR_RST;
         ssel_r <= `HMS_SSEL_RST;
         pmode_r <= PM_NEG_LOW;
         tos_r <= `HMS_TOS_RST;
         thyst_r <= `HMS_THYST_RST;
      end else begin
         if (store) val_r[ch_r] <= sample;
         if (wr_byte && first_r && !sens_r) idx_r <= wv;
         if (wr_byte && first_r && sens_r) ptr_r <= wv;
         if (wr_reg) begin
            if (in_lim) lim_r[lidx[3:0]] <= wv;
            case (idx_r)
               `HMS_CFG_ADDR: cfg_r <= wv;
               `HMS_PADDR_ADDR: paddr_r <= wv[6:0];
               `HMS_SSEL_ADDR: ssel_r <= wv;
               `HMS_PMODE_ADDR: pmode_r <= (wv[1:0] == 2'b11) ? PM_NEG_LOW : wv[1:0];
               default: ;
            endcase
         end
         // Two-byte sensor writes: high byte first, then low
         if (wr_sens) begin
            case (ptr_r[1:0])
               2'b01: scfg_r <= wv;
               2'b10: if (lo_r) thyst_r[7:0] <= wv; else thyst_r[15:8] <= wv;
               2'b11: if (lo_r) tos_r[7:0] <= wv; else tos_r[15:8] <= wv;
               default: ;
            endcase
         end
      end
   end
   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_r;
   assign adc_start = adc_start_r;
   // Shared pin channel follows the pin mode; 5 V channel uses the divider
   assign adc_chan = (ch_r == 4'(`HMS_CH_NEGPIN) && pmode_r != PM_NEG_LOW) ?
                     {2'b10, pmode_r} : ch_r;
   assign adc_int5v_sel = (ch_r == 4'(`HMS_CH_INT5V));
   assign neg_low_voltage_input_mode = pmode_r;
   assign beep = beep_r;
   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_store;
      @(posedge mclk) disable iff (srst)
      (mon_r == M_WAIT && adc_done) |=> (val_r[$past(ch_r)] == $past(adc_data));
   endproperty
   a_store: assert property (p_store) else $error("sample not stored");
   property p_status;
      @(posedge mclk) disable iff (srst)
      (mon_r == M_CMP && is_over && ch_r < 4'h8) |=> isr_r[$past(ch_r)];
   endproperty
   a_status: assert property (p_status) else $error("status not set");
   property p_beep;
      @(posedge mclk) disable iff (srst)
      (|over_r) |=> beep;
   endproperty
   a_beep: assert property (p_beep) else $error("beep missing");
   property p_paddr;
      @(posedge mclk) disable iff (srst)
      (st_r == S_ADDR && byte_end && sh_r[7:1] == paddr_r) |=> (sda_oe && st_r == S_ACK);
   endproperty
   a_paddr: assert property (p_paddr) else $error("primary address not acked");
   property p_saddr;
      @(posedge mclk) disable iff (srst)
      (st_r == S_ADDR && byte_end && sh_r[7:1] == saddr && !hit_p) |=> (sda_oe && sens_r);
   endproperty
   a_saddr: assert property (p_saddr) else $error("sensor address not acked");
   property p_index;
      @(posedge mclk) disable iff (srst)
      (wr_byte && first_r && !sens_r) |=> (idx_r == $past(sh_r));
   endproperty
   a_index: assert property (p_index) else $error("index not loaded");
   property p_twobyte;
      @(posedge mclk) disable iff (srst)
      (st_r == S_RD && scl_fall && cnt_r == `HMS_NBITS && !lo_r) |=> lo_r;
   endproperty
   a_twobyte: assert property (p_twobyte) else $error("byte order lost");
   property p_rdclr;
      @(posedge mclk) disable iff (srst)
      (clr1 && set_w[7:0] == 8'h00) |=> (isr_r[7:0] == 8'h00);
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("status not cleared");
endmodule // hms_serial_access

// File: hdl/hms_consts.svh
// Purpose: Offsets, reset values and counts for the monitor serial access block.
// Assumes: Included by bare name from the design files.
// Notes: Register offsets are byte indices on the primary serial address.
`ifndef HMS_CONSTS_SVH
`define HMS_CONSTS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define HMS_VAL_BASE 8'h20
`define HMS_LIM_BASE 8'h2b
`define HMS_CFG_ADDR 8'h40
`define HMS_ISR1_ADDR 8'h41
`define HMS_ISR2_ADDR 8'h42
`define HMS_PADDR_ADDR 8'h48
`define HMS_SSEL_ADDR 8'h4a
`define HMS_PMODE_ADDR 8'h5e
// ****************************************************************
// Reset values and fields
// ****************************************************************
`define HMS_PADDR_RST 7'h2d
`define HMS_SSEL_RST 8'h01
`define HMS_SENS_HI 4'h9
`define HMS_CFG_START 0
`define HMS_TOS_RST 16'h5000
`define HMS_THYST_RST 16'h4b00
`define HMS_LIM_RST 8'hff
// ****************************************************************
// Channel counts and converter weighting
// ****************************************************************
`define HMS_NCH 11
`define HMS_NADC 8
`define HMS_NBITS 4'h8
`define HMS_CH_NEGPIN 4
`define HMS_CH_INT5V 5
`define HMS_CH_TEMP1 7
`define HMS_LSB_UV 16000
`define HMS_FSR_MV 4096
`endif

// File: hdl/hms_pkg.sv
// Purpose: Types for the monitor serial access block.
// Assumes: Nothing beyond the consts header.
// Notes: States and modes only; numbers live in the header.
package hms_pkg;
   // Serial engine states
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_ADDR = 3'b001, S_ACK = 3'b010, S_WR = 3'b011,
      S_RD = 3'b100, S_RACK = 3'b101
   } hms_ser_t;
   // Sampling sequencer states
   typedef enum logic [1:0] {
      M_IDLE = 2'b00, M_CONV = 2'b01, M_WAIT = 2'b10, M_CMP = 2'b11
   } hms_mon_t;
   // Function of the shared analog pin
   typedef enum logic [1:0] {
      PM_NEG_LOW = 2'b00, PM_THERM2 = 2'b01, PM_DIODE2 = 2'b10
   } hms_pmode_t;
endpackage : hms_pkg

// File: dv/hms_host_model.sv
// Purpose: Serial bus host that drives scl and sda for the monitor block.
// Assumes: Open-drain bus with pull-ups; all changes land on the falling mclk edge.
// Notes: The scl high phase lasts HALF mclk cycles and the low phase twice that, above the block's minimum.
module hms_host_model #(
   parameter int HALF = 5
) (
   // Clock
   input wire logic mclk,
   // Bus pins
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Bus conditions
   // ****************************************************************
   // Both lines released at time zero, as the pull-ups leave them
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick();
      repeat (HALF) @(negedge mclk);
   endtask
   // Also serves as repeated start: sda rises only while scl is low
   task automatic start();
      sda_drv = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b0;
      tick();
      scl = 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b1;
      tick();
   endtask
   // ****************************************************************
   // Bits and bytes, most significant bit first
   // ****************************************************************
   // Line sampled late in the high phase, long after the device settles it
   task automatic xfer_bit(input logic b, output logic s);
      sda_drv = b;
      tick();
      scl = 1'b1;
      tick();
      s = sda_line;
      scl = 1'b0;
      tick();
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(b[i], s);
      end
      xfer_bit(1'b1, s);
      ack = ~s;
   endtask
   // Last byte gets a nack so the device lets go of the line
   task automatic rbyte(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, s);
         d[i] = s;
      end
      xfer_bit(last, s);
   endtask
endmodule // hms_host_model

// File: dv/hms_serial_access_tb.sv
// Purpose: Self-checking bench for the monitor serial access block.
// Assumes: Host model on the bus, a simple converter model in this module.
// Notes: Converter returns 30h plus the channel code; fans are fixed counts.
module hms_serial_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic scl, host_sda, sda_line, sda_o, sda_oe, adc_start, adc_int5v_sel, beep;
   logic adc_done = 1'b0;
   logic [3:0] adc_chan;
   logic [7:0] adc_data = 8'h00;
   logic [23:0] fan_cnt = 24'h838281;
   logic [1:0] pin_mode;
   logic [6:0] pa = 7'h2d;
   logic [6:0] sa = 7'h49;
   logic saw5 = 1'b0;
   logic odd5 = 1'b0;
   logic a;
   int cnt = 0;
   int bad_count = 0;
   int n_checks = 0;
   // ****************************************************************
   // Clock, wire and instances
   // ****************************************************************
   always #5 mclk = ~mclk;
   // Open drain: either party may pull the line low
   assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);
   hms_serial_access i_dut (.mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .adc_start(adc_start), .adc_chan(adc_chan),
      .adc_int5v_sel(adc_int5v_sel), .adc_done(adc_done), .adc_data(adc_data),
      .fan_cnt(fan_cnt), .neg_low_voltage_input_mode(pin_mode), .beep(beep));
   hms_host_model i_host (.mclk(mclk), .scl(scl), .sda_drv(host_sda), .sda_line(sda_line));
   // Converter answers three cycles after each start pulse
   always @(negedge mclk) begin
      adc_done <= 1'b0;
      if (adc_start === 1'b1) begin
         cnt <= 3;
         if (adc_chan === 4'h5) saw5 <= adc_int5v_sel;
         else if (adc_int5v_sel !== 1'b0) odd5 <= 1'b1;
      end else if (cnt == 1) begin
         adc_done <= 1'b1;
         adc_data <= 8'h30 + {4'h0, adc_chan};
         cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
   end
   // ****************************************************************
   // Checks and bus transactions
   // ****************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Reset leaves every output at its idle level
   task automatic rst_chk();
      chk({adc_chan, sda_oe, adc_start, beep, adc_int5v_sel}, 8'h00);
      chk({6'h0, pin_mode}, 8'h00);
   endtask
   task automatic wrap_up();
      $display("Checks made: %0d, mismatches: %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Primary write of an index, with or without a data byte
   task automatic pw(input logic [7:0] idx, input logic [7:0] d, input logic has_d);
      i_host.start();
      i_host.wbyte({pa, 1'b0}, a);
      chk({7'h0, a}, 8'h01);
      i_host.wbyte(idx, a);
      chk({7'h0, a}, 8'h01);
      if (has_d) begin
         i_host.wbyte(d, a);
         chk({7'h0, a}, 8'h01);
      end
      i_host.stop();
   endtask
   // Index-only write, then a separate read of that register
   task automatic pr(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      pw(idx, 8'h00, 1'b0);
      i_host.start();
      i_host.wbyte({pa, 1'b1}, a);
      chk({7'h0, a}, 8'h01);
      i_host.rbyte(d, 1'b1);
      i_host.stop();
      chk(d, exp);
   endtask
   // Address-only probe; expect tells whether an ack is due
   task automatic probe(input logic [6:0] adr, input logic expect_ack);
      i_host.start();
      i_host.wbyte({adr, 1'b0}, a);
      i_host.stop();
      chk({7'h0, a}, {7'h0, expect_ack});
   endtask
   // Sensor write of a pointer and n data bytes, high byte first
   task automatic sw(input logic [7:0] ptr, input int n, input logic [15:0] d);
      i_host.start();
      i_host.wbyte({sa, 1'b0}, a);
      chk({7'h0, a}, 8'h01);
      i_host.wbyte(ptr, a);
      chk({7'h0, a}, 8'h01);
      for (int i = 0; i < n; i++) begin
         i_host.wbyte(i == 0 ? d[15:8] : d[7:0], a);
         chk({7'h0, a}, 8'h01);
      end
      i_host.stop();
   endtask
   // Sensor read of n bytes, optionally after a fresh pointer and repeated start
   task automatic sr(input logic set, input logic [7:0] ptr, input int n, input logic [15:0] exp);
      logic [7:0] hi;
      logic [7:0] lo;
      i_host.start();
      if (set) begin
         i_host.wbyte({sa, 1'b0}, a);
         chk({7'h0, a}, 8'h01);
         i_host.wbyte(ptr, a);
         chk({7'h0, a}, 8'h01);
         i_host.start();
      end
      i_host.wbyte({sa, 1'b1}, a);
      chk({7'h0, a}, 8'h01);
      i_host.rbyte(hi, n == 1);
      chk(hi, exp[15:8]);
      if (n == 2) begin
         i_host.rbyte(lo, 1'b1);
         chk(lo, exp[7:0]);
      end
      i_host.stop();
   endtask
   // Run the sampler for a while, then halt it so status stays put
   task automatic sweep();
      pw(8'h40, 8'h01, 1'b1);
      repeat (600) @(negedge mclk);
      pw(8'h40, 8'h00, 1'b1);
      repeat (200) @(negedge mclk);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   // Hang guard: a stuck run is a mismatch and ends in the report
   initial begin
      repeat (100000) @(posedge mclk);
      bad_count++;
      $display("ERROR at %0t: run did not finish", $time);
      wrap_up();
   end
   initial begin
      repeat (5) @(negedge mclk);
      srst = 1'b0;
      rst_chk();
      pr(8'h48, 8'h2d);
      pr(8'h4a, 8'h01);
      pr(8'h2b, 8'hff);
      probe(7'h2c, 1'b0);
      // Ch2 above, ch3 equal to, fan ch9 above their limits
      pw(8'h2d, 8'h31, 1'b1);
      pw(8'h2e, 8'h33, 1'b1);
      pw(8'h34, 8'h81, 1'b1);
      pr(8'h2d, 8'h31);
      pw(8'h40, 8'h01, 1'b1);
      repeat (600) @(negedge mclk);
      chk({7'h0, beep}, 8'h01);
      pw(8'h40, 8'h00, 1'b1);
      repeat (200) @(negedge mclk);
      for (int i = 0; i < 8; i++) pr(8'h20 + i[7:0], 8'h30 + i[7:0]);
      for (int i = 0; i < 3; i++) pr(8'h28 + i[7:0], 8'h81 + i[7:0]);
      pr(8'h41, 8'h04);
      pr(8'h41, 8'h00);
      pr(8'h42, 8'h02);
      pr(8'h42, 8'h00);
      chk({7'h0, saw5}, 8'h01);
      chk({7'h0, odd5}, 8'h00);
      sr(1'b1, 8'h00, 2, 16'h3700);
      sr(1'b1, 8'h03, 2, 16'h5000);
      sr(1'b0, 8'h03, 2, 16'h5000);
      sr(1'b1, 8'h02, 2, 16'h4b00);
      sw(8'h03, 2, 16'h5580);
      sr(1'b1, 8'h03, 2, 16'h5580);
      sw(8'h01, 1, 16'h0200);
      sr(1'b1, 8'h01, 1, 16'h0200);
      sr(1'b0, 8'h01, 1, 16'h0200);
      pw(8'h4a, 8'h03, 1'b1);
      sa = 7'h4b;
      probe(7'h49, 1'b0);
      probe(7'h4b, 1'b1);
      pw(8'h48, 8'h2e, 1'b1);
      pa = 7'h2e;
      probe(7'h2d, 1'b0);
      probe(7'h2e, 1'b1);
      // Over-temperature high byte below the sensor value raises its status bit
      sw(8'h03, 2, 16'h3000);
      for (int m = 1; m < 3; m++) begin
         pw(8'h5e, m[7:0], 1'b1);
         chk({6'h0, pin_mode}, m[7:0]);
         sweep();
         pr(8'h24, m == 1 ? 8'h39 : 8'h3a);
      end
      pr(8'h41, 8'h04);
      pr(8'h42, 8'h0a);
      // Second reset in mid-run: addresses, the over-temperature limit and pin mode return
      srst = 1'b1;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      rst_chk();
      pa = 7'h2d;
      sa = 7'h49;
      pr(8'h48, 8'h2d);
      pr(8'h4a, 8'h01);
      sr(1'b1, 8'h03, 2, 16'h5000);
      // Mode code 3 is not a pin function and falls back to the negative input
      pw(8'h5e, 8'h02, 1'b1);
      pw(8'h5e, 8'h03, 1'b1);
      chk({6'h0, pin_mode}, 8'h00);
      wrap_up();
   end
endmodule // hms_serial_access_tb
